//--- hw/cis_defines.vh
// Constants for the cyclic status image: slot addresses, field positions,
// codes and reset values. Included by the status image module; the capture counter does not use it.
// What this block does
// - Drive state word bits 0-3 carry the binary operating state, 1..9.
// - State word bit 6 error class 1-3, bit 7 class 0, bit 8 halt.
// - State word bit 14 is 0 once mode starts, 1 once it ends; bit 13 info.
// - State word bit 15 shows whether an operating mode error is present.
// - Mode status bits 0-3 report the set mode: 1,2,3,4 or 7.
// - Mode status bit 5 follows validity of the position zero point.
// - Mode status bit 6 set when a toggled mode request is rejected.
// - Input byte bits 0-3 mirror logic inputs, bits 4-5 the safety channels.
// - Factory mapping: bit 0 positive limit, 1 negative, 2 free, 3 home.
// - Motion word bit 6 stationary, 7 moving positive, 8 moving negative.
// - Motion word bit 9 set while position deviation is inside its window.
// - Motion word bits 11-14: rest, slowing, speeding up, constant velocity.
// - Capture word bits 0-1 and 2-3 hold low counter bits of captures 1, 2.
// - First slot: state word, mode and input bytes; second: motion, capture.
// - A mode request counts only if its toggle bit changed since last time.
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH

// Parameter addresses of the two input slots, 6926 and 6928
`define CIS_SLOT0_ADDR 16'h1b0e
`define CIS_SLOT1_ADDR 16'h1b10

// Drive state word fields
`define CIS_DS_STATE_LSB 0
`define CIS_DS_ERROR_BIT 6
`define CIS_DS_WARN_BIT 7
`define CIS_DS_HALT_BIT 8
`define CIS_DS_INFO_BIT 13
`define CIS_DS_END_BIT 14
`define CIS_DS_MERR_BIT 15
`define CIS_STATE_MIN 4'h1
`define CIS_STATE_MAX 4'h9
`define CIS_STATE_RST 4'h1

// Mode status byte fields and mode codes
`define CIS_MS_MODE_LSB 0
`define CIS_MS_REF_BIT 5
`define CIS_MS_REJ_BIT 6
`define CIS_MS_TGL_BIT 7
`define CIS_MODE_JOG 4'h1
`define CIS_MODE_HOME 4'h2
`define CIS_MODE_PPOS 4'h3
`define CIS_MODE_PVEL 4'h4
`define CIS_MODE_SPD 4'h7
`define CIS_MODE_RST 4'h0

// Input state byte fields
`define CIS_IN_LOGIC_LSB 0
`define CIS_IN_SAFE_A_BIT 4
`define CIS_IN_SAFE_B_BIT 5

// Motion flags word fields
`define CIS_MF_STOP_BIT 6
`define CIS_MF_POS_BIT 7
`define CIS_MF_NEG_BIT 8
`define CIS_MF_WIN_BIT 9
`define CIS_MF_REST_BIT 11
`define CIS_MF_DEC_BIT 12
`define CIS_MF_ACC_BIT 13
`define CIS_MF_PROFILE_CONSTANT_VELOCITY_BIT 14

// Profile generator phase codes on the phase input
`define CIS_PH_REST 2'h0
`define CIS_PH_DEC 2'h1
`define CIS_PH_ACC 2'h2
`define CIS_PH_PROFILE_CONSTANT_VELOCITY 2'h3

// Capture count word fields
`define CIS_CC_CAP1_LSB 0
`define CIS_CC_CAP2_LSB 2

// Reset values of the image words
`define CIS_WORD_RST 16'h0000
`define CIS_BYTE_RST 8'h00

`endif

//--- hw/cis_capture_count.v
// Two-bit event counter for one capture input.
// Assumes a one-cycle event pulse synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module cis_capture_count (
   input wire core_clk,
   input wire rst,
   input wire event_pulse,
   output reg [1:0] count_ff
);
   wire [1:0] nxt_count;

   // Wraps freely; only the low bits are ever reported
   assign nxt_count = event_pulse ? count_ff + 2'h1 : count_ff;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_ff <= 2'h0;
      end else begin
         count_ff <= nxt_count;
      end
   end
endmodule // cis_capture_count
`default_nettype wire

//--- hw/cis_status_image.v
// Cyclic status image of the drive: collects drive, mode, input, motion
// and capture status into two 32-bit slots answered to scan reads.
// Assumes all status inputs are synchronous to core_clk and that the
// command side delivers one cmd_valid pulse per received output image.
`timescale 1ns/1ps
`include "cis_defines.vh"
`default_nettype none
module cis_status_image (
   input wire core_clk,
   input wire rst,
   // Scan read port
   input wire rd_req,
   input wire [15:0] rd_addr,
   output reg rd_valid_ff,
   output reg [31:0] rd_data_ff,
   output reg rd_err_ff,
   // Drive state machine
   input wire [3:0] drive_state,
   input wire error_active,
   input wire warn_active,
   input wire halt_active,
   input wire mode_specific_info,
   input wire mode_started,
   input wire mode_terminated,
   input wire mode_error,
   // Mode command byte from the output image
   input wire cmd_valid,
   input wire [7:0] cmd_mode_ctrl,
   // Mode request hand-off to the mode engine
   output reg mode_req_ff,
   output reg [7:0] mode_req_ctrl_ff,
   input wire mode_done,
   input wire mode_rejected,
   input wire ref_valid,
   // Pins and motion status
   input wire logic_input_1,
   input wire logic_input_2,
   input wire logic_input_3,
   input wire logic_input_4,
   input wire safety_input_a,
   input wire safety_input_b,
   input wire motor_zero_speed,
   input wire motor_dir_neg,
   input wire [15:0] pos_deviation,
   input wire [15:0] pos_window,
   input wire [1:0] profile_phase,
   input wire capture_1_event,
   input wire capture_2_event
);
   // Image registers
   reg [3:0] state_ff;
   reg error_ff;
   reg warn_ff;
   reg halt_ff;
   reg info_ff;
   reg mode_end_ff;
   reg mode_err_ff;
   reg [3:0] mode_ff;
   reg ref_ok_ff;
   reg request_rejected_ff;
   reg toggle_echo_ff;
   reg [5:0] inputs_ff;
   reg motor_stopped_ff;
   reg motor_moving_positive_ff;
   reg motor_moving_negative_ff;
   reg in_position_window_ff;
   reg [3:0] profile_ff;
   // Toggle tracking
   reg last_toggle_ff;
   reg pending_ff;
   reg pending_toggle_ff;
   reg [3:0] pending_mode_ff;

   wire [1:0] cap1_count;
   wire [1:0] cap2_count;
   wire [15:0] abs_dev;
   wire toggled;
   reg [15:0] drive_state_word;
   reg [7:0] mode_status_byte;
   reg [7:0] input_state_byte;
   reg [15:0] motion_flags_word;
   reg [15:0] capture_count_word;
   reg [3:0] nxt_state;
   reg [3:0] nxt_profile;
   reg nxt_mode_end;

   // One counter per capture input
   cis_capture_count u_cap1 (
      .core_clk(core_clk),
      .rst(rst),
      .event_pulse(capture_1_event),
      .count_ff(cap1_count)
   );

   cis_capture_count u_cap2 (
      .core_clk(core_clk),
      .rst(rst),
      .event_pulse(capture_2_event),
      .count_ff(cap2_count)
   );

   // Out-of-range state codes keep the last good value
   always @* begin
      nxt_state = state_ff;
      if (drive_state >= `CIS_STATE_MIN && drive_state <= `CIS_STATE_MAX) begin
         nxt_state = drive_state;
      end
   end

   // Terminated wins if both arrive together, the mode is then over;
   // between pulses the last reported phase of the mode is held
   always @* begin
      nxt_mode_end = mode_end_ff;
      if (mode_started) begin
         nxt_mode_end = 1'b0;
      end
      if (mode_terminated) begin
         nxt_mode_end = 1'b1;
      end
   end

   // Operating state code; out-of-range codes were filtered above
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= `CIS_STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Error, halt and operating mode flags of the state word
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         error_ff <= 1'b0;
         warn_ff <= 1'b0;
         halt_ff <= 1'b0;
         info_ff <= 1'b0;
         mode_end_ff <= 1'b0;
         mode_err_ff <= 1'b0;
      end else begin
         error_ff <= error_active;
         warn_ff <= warn_active;
         halt_ff <= halt_active;
         info_ff <= mode_specific_info;
         mode_end_ff <= nxt_mode_end;
         mode_err_ff <= mode_error;
      end
   end

   // A new request only when the toggle bit changed level
   assign toggled = cmd_valid && (cmd_mode_ctrl[`CIS_MS_TGL_BIT] !=
                    last_toggle_ff);

   // Toggle tracking and request hand-off. An all-zero byte is not
   // processed, but its toggle level is still remembered so the next
   // change is judged against what the master last sent.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_toggle_ff <= 1'b0;
         mode_req_ff <= 1'b0;
         mode_req_ctrl_ff <= `CIS_BYTE_RST;
         pending_ff <= 1'b0;
         pending_toggle_ff <= 1'b0;
         pending_mode_ff <= `CIS_MODE_RST;
      end else begin
         mode_req_ff <= 1'b0;
         if (cmd_valid) begin
            last_toggle_ff <= cmd_mode_ctrl[`CIS_MS_TGL_BIT];
         end
         if (toggled && cmd_mode_ctrl != `CIS_BYTE_RST) begin
            mode_req_ff <= 1'b1;
            mode_req_ctrl_ff <= cmd_mode_ctrl;
            pending_ff <= 1'b1;
            pending_toggle_ff <= cmd_mode_ctrl[`CIS_MS_TGL_BIT];
            pending_mode_ff <= cmd_mode_ctrl[3:0];
         end else if (mode_done) begin
            pending_ff <= 1'b0;
         end
      end
   end

   // Mode status: outcome of the last processed request. A reject in the
   // same cycle as an accept cannot happen; done carries both outcomes.
   // The reject flag stands until the next processed request, so a
   // master polling slowly still sees it before it toggles again.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_ff <= `CIS_MODE_RST;
         ref_ok_ff <= 1'b0;
         request_rejected_ff <= 1'b0;
         toggle_echo_ff <= 1'b0;
      end else begin
         ref_ok_ff <= ref_valid;
         if (mode_done && pending_ff) begin
            toggle_echo_ff <= pending_toggle_ff;
            request_rejected_ff <= mode_rejected;
            if (!mode_rejected) begin
               mode_ff <= pending_mode_ff;
            end
         end
      end
   end

   // Magnitude of the signed deviation; the most negative value comes
   // out as 16'h8000, which is still exact when read as unsigned
   assign abs_dev = pos_deviation[15] ? (~pos_deviation + 16'h0001)
                    : pos_deviation;

   // Exactly one profile phase bit is set at a time
   always @* begin
      case (profile_phase)
         `CIS_PH_REST: nxt_profile = 4'h1;
         `CIS_PH_DEC: nxt_profile = 4'h2;
         `CIS_PH_ACC: nxt_profile = 4'h4;
         `CIS_PH_PROFILE_CONSTANT_VELOCITY: nxt_profile = 4'h8;
         default: nxt_profile = 4'h1;
      endcase
   end

   // Pin mirror; pins are taken as already clean and synchronous
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         inputs_ff <= 6'h00;
      end else begin
         // Factory order: positive limit, negative limit, free, home
         inputs_ff <= {safety_input_b, safety_input_a, logic_input_4,
                       logic_input_3, logic_input_2,
                       logic_input_1};
      end
   end

   // Motion direction; reset reports standstill so that the three
   // flags are one-hot from the very first read after reset
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         motor_stopped_ff <= 1'b1;
         motor_moving_positive_ff <= 1'b0;
         motor_moving_negative_ff <= 1'b0;
      end else begin
         motor_stopped_ff <= motor_zero_speed;
         motor_moving_positive_ff <= !motor_zero_speed &&
                                     !motor_dir_neg;
         motor_moving_negative_ff <= !motor_zero_speed &&
                                     motor_dir_neg;
      end
   end

   // Deviation window, inclusive at its edge
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_position_window_ff <= 1'b0;
      end else begin
         in_position_window_ff <= (abs_dev <= pos_window);
      end
   end

   // Profile phase; reset reports the generator at rest, still one-hot
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         profile_ff <= 4'h1;
      end else begin
         profile_ff <= nxt_profile;
      end
   end

   // Word assembly from the field positions; every bit not written
   // below keeps the zero default, which is what reserved bits read
   always @* begin
      drive_state_word = `CIS_WORD_RST;
      drive_state_word[`CIS_DS_STATE_LSB +: 4] = state_ff;
      drive_state_word[`CIS_DS_ERROR_BIT] = error_ff;
      drive_state_word[`CIS_DS_WARN_BIT] = warn_ff;
      drive_state_word[`CIS_DS_HALT_BIT] = halt_ff;
      drive_state_word[`CIS_DS_INFO_BIT] = info_ff;
      drive_state_word[`CIS_DS_END_BIT] = mode_end_ff;
      drive_state_word[`CIS_DS_MERR_BIT] = mode_err_ff;
   end

   // Mode status byte: set mode, zero point, outcome of last request
   always @* begin
      mode_status_byte = `CIS_BYTE_RST;
      mode_status_byte[`CIS_MS_MODE_LSB +: 4] = mode_ff;
      mode_status_byte[`CIS_MS_REF_BIT] = ref_ok_ff;
      mode_status_byte[`CIS_MS_REJ_BIT] = request_rejected_ff;
      mode_status_byte[`CIS_MS_TGL_BIT] = toggle_echo_ff;
   end

   // Input state byte: four logic inputs, then both safety channels
   always @* begin
      input_state_byte = `CIS_BYTE_RST;
      input_state_byte[`CIS_IN_LOGIC_LSB +: 4] = inputs_ff[3:0];
      input_state_byte[`CIS_IN_SAFE_A_BIT] = inputs_ff[4];
      input_state_byte[`CIS_IN_SAFE_B_BIT] = inputs_ff[5];
   end

   // Motion flags word: direction, window and profile phase
   always @* begin
      motion_flags_word = `CIS_WORD_RST;
      motion_flags_word[`CIS_MF_STOP_BIT] = motor_stopped_ff;
      motion_flags_word[`CIS_MF_POS_BIT] = motor_moving_positive_ff;
      motion_flags_word[`CIS_MF_NEG_BIT] = motor_moving_negative_ff;
      motion_flags_word[`CIS_MF_WIN_BIT] = in_position_window_ff;
      motion_flags_word[`CIS_MF_REST_BIT] = profile_ff[0];
      motion_flags_word[`CIS_MF_DEC_BIT] = profile_ff[1];
      motion_flags_word[`CIS_MF_ACC_BIT] = profile_ff[2];
      motion_flags_word[`CIS_MF_PROFILE_CONSTANT_VELOCITY_BIT] = profile_ff[3];
   end

   // Capture count word: low two bits of each event counter
   always @* begin
      capture_count_word = `CIS_WORD_RST;
      capture_count_word[`CIS_CC_CAP1_LSB +: 2] = cap1_count;
      capture_count_word[`CIS_CC_CAP2_LSB +: 2] = cap2_count;
   end

   // Read answer one cycle after the request; byte 0 is sent first so
   // it sits in the top byte, as the fieldbus is big-endian. Slot 0 is
   // state word, mode byte, input byte; slot 1 is motion word, then
   // capture word. Unmapped addresses answer zero data with the error
   // flag, so the master never mistakes a stale slot for a fresh one.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= 32'h00000000;
         rd_err_ff <= 1'b0;
      end else begin
         rd_valid_ff <= rd_req;
         rd_err_ff <= 1'b0;
         if (rd_req) begin
            case (rd_addr)
               `CIS_SLOT0_ADDR: rd_data_ff <= {drive_state_word,
                  mode_status_byte, input_state_byte};
               `CIS_SLOT1_ADDR: rd_data_ff <= {motion_flags_word,
                  capture_count_word};
               default: begin
                  rd_data_ff <= 32'h00000000;
                  rd_err_ff <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // cis_status_image
`default_nettype wire

//--- verification/cis_status_image_chk.sv
// Checker for the cyclic status image: read answers and mode requests.
// Bound to cis_status_image; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cis_status_image_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic rd_valid_ff,
   input wire logic [31:0] rd_data_ff,
   input wire logic rd_err_ff,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_mode_ctrl,
   input wire logic mode_req_ff,
   input wire logic [7:0] mode_req_ctrl_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Read requests by target
   sequence s_rd0; rd_req && rd_addr == 16'h1b0e; endsequence
   sequence s_rd1; rd_req && rd_addr == 16'h1b10; endsequence
   sequence s_bad; rd_req && rd_addr != 16'h1b0e && rd_addr != 16'h1b10;
   endsequence
   AST_LAT: assert property (rd_req |=> rd_valid_ff)
      else $error("read answer missing");
   AST_ERR: assert property (s_bad |=> rd_err_ff &&
      rd_data_ff == 32'h0)
      else $error("unmapped read not refused");
   // Reserved bits of both slots stay clear
   AST_RSV0: assert property (s_rd0 |=>
      (rd_data_ff & 32'h1e3010c0) == 32'h0)
      else $error("slot 0 reserved bit set");
   AST_RSV1: assert property (s_rd1 |=>
      (rd_data_ff & 32'h843ffff0) == 32'h0)
      else $error("slot 1 reserved bit set");
   AST_MOT: assert property (s_rd1 |=> $onehot(rd_data_ff[24:22]))
      else $error("motion flags not one-hot");
   AST_PH: assert property (s_rd1 |=> $onehot(rd_data_ff[30:27]))
      else $error("profile phase not one-hot");
   // A request pulse carries the byte taken one edge before
   AST_REQ: assert property (mode_req_ff |-> $past(cmd_valid) &&
      mode_req_ctrl_ff == $past(cmd_mode_ctrl))
      else $error("mode request without command");
   AST_ZERO: assert property (cmd_valid && cmd_mode_ctrl == 8'h00
      |=> !mode_req_ff)
      else $error("zero command byte processed");
endmodule // cis_status_image_chk
bind cis_status_image cis_status_image_chk i_cis_status_image_chk (
   .core_clk, .rst, .rd_req, .rd_addr, .rd_valid_ff, .rd_data_ff,
   .rd_err_ff, .cmd_valid, .cmd_mode_ctrl, .mode_req_ff, .mode_req_ctrl_ff);
`default_nettype wire

//--- verification/cis_master_model.sv
// Scanning master: reads the input slots, sends mode command bytes.
// Drives everything just after the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module cis_master_model (
   input wire logic core_clk,
   output logic rd_req,
   output logic [15:0] rd_addr,
   output logic cmd_valid,
   output logic [7:0] cmd_mode_ctrl
);
   logic tgl;
   initial begin
      {rd_req, rd_addr, cmd_valid, cmd_mode_ctrl, tgl} = 27'h0;
   end
   // Two back-to-back slot reads make one eight-byte scan
   task automatic scan(input logic [15:0] a0, a1);
      @(negedge core_clk);
      rd_req = 1'b1;
      rd_addr = a0;
      @(negedge core_clk);
      rd_addr = a1;
      @(negedge core_clk);
      rd_req = 1'b0;
      rd_addr = ~a1; // Inverted, so no stale address lingers
   endtask
   // A new request flips the toggle; a repeat keeps it
   task automatic send(input logic [6:0] body, input logic flip);
      @(negedge core_clk);
      if (flip) tgl = ~tgl;
      cmd_valid = 1'b1;
      cmd_mode_ctrl = {tgl, body};
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd_mode_ctrl = ~cmd_mode_ctrl;
   endtask
endmodule // cis_master_model
`default_nettype wire

//--- verification/cis_status_image_tb_top.sv
// Testbench of the cyclic status image: random status, mode requests,
// scans. Expects the checker bound and the master model beside it.
`timescale 1ns/1ps
`default_nettype none
module cis_status_image_tb_top;
   logic core_clk = 1'b0, rst = 1'b1, rd_req, cmd_valid;
   logic [15:0] rd_addr, pos_deviation, pos_window;
   logic [7:0] cmd_mode_ctrl, mode_req_ctrl_ff;
   logic [3:0] drive_state, e_st, e_mode;
   logic [5:0] pins;
   logic [1:0] profile_phase, c1, c2;
   logic error_active, warn_active, halt_active, mode_specific_info;
   logic mode_started, mode_terminated, mode_error, mode_done, ref_valid;
   logic mode_rejected, motor_zero_speed, motor_dir_neg, capture_1_event;
   logic capture_2_event, rd_valid_ff, rd_err_ff, mode_req_ff, e_end;
   logic e_rej, e_tgl;
   logic [31:0] rd_data_ff;
   logic [32:0] note;
   logic [32:0] expq[$];
   logic [3:0] modes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
   int failures = 0, checked = 0, cyc = 0;
   always #10 core_clk = ~core_clk;
   cis_status_image i_cis_status_image (.core_clk, .rst, .rd_req, .rd_addr,
      .rd_valid_ff, .rd_data_ff, .rd_err_ff, .drive_state, .error_active,
      .warn_active, .halt_active, .mode_specific_info, .mode_started,
      .mode_terminated, .mode_error, .cmd_valid, .cmd_mode_ctrl,
      .mode_req_ff, .mode_req_ctrl_ff, .mode_done, .mode_rejected,
      .ref_valid, .logic_input_1(pins[0]), .logic_input_2(pins[1]),
      .logic_input_3(pins[2]), .logic_input_4(pins[3]),
      .safety_input_a(pins[4]), .safety_input_b(pins[5]),
      .motor_zero_speed, .motor_dir_neg, .pos_deviation, .pos_window,
      .profile_phase, .capture_1_event, .capture_2_event);
   cis_master_model i_cis_master_model (.core_clk, .rd_req, .rd_addr,
      .cmd_valid, .cmd_mode_ctrl);
   task automatic chk(input string n, input logic [31:0] e, s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task end_of_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Expected slots from the bench's own view of the inputs
   function logic [32:0] exp_of(input logic [15:0] a);
      logic [16:0] mag;
      mag = pos_deviation[15] ? 17'h0 - {1'b1, pos_deviation}
         : {1'b0, pos_deviation};
      if (a == 16'h1b0e) return {1'b0, mode_error, e_end, mode_specific_info,
         4'h0, halt_active, warn_active, error_active, 2'h0, e_st, e_tgl,
         e_rej, ref_valid, 1'b0, e_mode, 2'h0, pins};
      if (a == 16'h1b10) return {2'h0, 4'h1 << profile_phase, 1'b0,
         mag <= {1'b0, pos_window}, motor_zero_speed ? 3'h1 :
         motor_dir_neg ? 3'h4 : 3'h2, 18'h0, c2, c1};
      return {1'b1, 32'h0};
   endfunction
   // Random status levels, then three cycles of event pulses
   task automatic set_inputs(input logic [3:0] st);
      @(negedge core_clk);
      drive_state = st;
      if (st >= 4'h1 && st <= 4'h9) e_st = st;
      {error_active, warn_active, halt_active, mode_specific_info, mode_error,
         ref_valid, motor_zero_speed, motor_dir_neg} = 8'($urandom);
      {pins, profile_phase} = 8'($urandom);
      pos_deviation = 16'($urandom % 64) - 16'd32; // Near window edge
      pos_window = 16'($urandom % 34);
      repeat (3) begin
         {mode_started, mode_terminated, capture_1_event,
            capture_2_event} = 4'($urandom);
         @(negedge core_clk);
         if (mode_terminated) e_end = 1'b1;
         else if (mode_started) e_end = 1'b0;
         c1 = c1 + 2'(capture_1_event);
         c2 = c2 + 2'(capture_2_event);
      end
      {mode_started, mode_terminated, capture_1_event, capture_2_event} = 0;
   endtask
   task automatic do_mode(input logic [6:0] body, input logic flip, go);
      logic [7:0] want;
      i_cis_master_model.send(body, flip);
      want = {i_cis_master_model.tgl, body};
      chk("mode_req_ff", 32'(go), 32'(mode_req_ff));
      if (go) begin
         chk("mode_req_ctrl_ff", 32'(want), 32'(mode_req_ctrl_ff));
         mode_done = 1'b1;
         mode_rejected = 1'($urandom);
         @(negedge core_clk);
         e_tgl = want[7];
         e_rej = mode_rejected;
         if (!mode_rejected) e_mode = body[3:0];
         {mode_done, mode_rejected} = 2'h0;
      end
   endtask
   task automatic scan(input logic [15:0] a0, a1);
      @(negedge core_clk);
      expq.push_back(exp_of(a0));
      expq.push_back(exp_of(a1));
      i_cis_master_model.scan(a0, a1);
      @(negedge core_clk);
   endtask
   // Each answer against the oldest note
   always @(negedge core_clk) begin
      if (rd_valid_ff === 1'b1) begin
         if (expq.size() == 0) chk("rd_valid_ff", 32'h0, 32'h1);
         else begin
            note = expq.pop_front();
            chk("rd_data_ff", note[31:0], rd_data_ff);
            chk("rd_err_ff", 32'(note[32]), 32'(rd_err_ff));
         end
      end
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      {drive_state, pins, profile_phase, pos_deviation, pos_window} = 0;
      {error_active, warn_active, halt_active, mode_specific_info,
         mode_started, mode_terminated, mode_error, mode_done, ref_valid,
         mode_rejected, motor_zero_speed, motor_dir_neg, capture_1_event,
         capture_2_event} = 0;
      {e_st, e_mode, e_end, e_rej, e_tgl, c1, c2} = {4'h1, 11'h0};
      void'($urandom(32'h89eeeb20));
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      scan(16'h1b0e, 16'h1b10);
      for (int i = 0; i < 9; i++) begin
         set_inputs(4'(i + 1));
         do_mode({3'($urandom), modes[i % 5]}, 1'b1, 1'b1);
         scan(16'h1b0e, 16'h1b10);
      end
      set_inputs(4'hc);
      do_mode(7'h00, 1'b1, 1'b0);
      do_mode(7'h02, 1'b0, 1'b0);
      do_mode(7'h12, 1'b1, 1'b1);
      scan(16'h1b12, 16'h1b0e);
      chk("pending", 32'h0, 32'(expq.size()));
      end_of_test();
   end
endmodule // cis_status_image_tb_top
`default_nettype wire
